/* File: design/pfp_pkg.sv */
/*
  Package for the parallel flash programming controller: commands, select codes,
  pin bundles and timing counts at a 40 MHz core clock.
  Assumes the device pins are reached through level shifters outside this block.
*/
// Contract
// - Erase whole array before rewriting bytes; the controller does not enforce this, and the bench rewrites a byte unerased
// - Select levels choose write, lock, erase
// - Read select drives code byte out
// - High voltage, then one strobe pulse
// - Verify by lowering reset to high
// - Erase: strobe low 10 ms
// - Programmer advances counter per byte
// - Power-up: reset, increment low first
// - Power-off: increment, then reset low
package pfp_pkg;
  localparam int unsigned CLK_HZ        = 40_000_000;
  localparam int unsigned US_PER_S      = 1_000_000;
  // Times in microseconds as printed, increment high time in nanoseconds
  localparam int unsigned T_SETUP_US    = 10;
  localparam int unsigned T_WRITE_STROBE_W_US   = 1;
  localparam int unsigned T_ERASE_US    = 10_000;
  localparam int unsigned T_WC_US       = 2_000;
  localparam int unsigned T_INC_HI_NS   = 200;
  localparam int unsigned T_BHIH_US     = 1;
  localparam int unsigned NS_PER_S      = 1_000_000_000;
  // Least times round up
  localparam int unsigned SETUP_CYC  = (T_SETUP_US * (CLK_HZ / US_PER_S));
  localparam int unsigned PROGW_CYC  = (T_WRITE_STROBE_W_US * (CLK_HZ / US_PER_S)) + 4;
  localparam int unsigned ERASE_CYC  = (T_ERASE_US * (CLK_HZ / US_PER_S));
  localparam int unsigned WC_CYC     = (T_WC_US * (CLK_HZ / US_PER_S));
  localparam int unsigned INC_CYC    = (T_INC_HI_NS * (CLK_HZ / 1000) + NS_PER_S / 1000 - 1)
                                       / (NS_PER_S / 1000);
  localparam int unsigned BHIH_CYC   = (T_BHIH_US * (CLK_HZ / US_PER_S));
  localparam int unsigned CNT_W      = 24;
  localparam int unsigned DATA_W     = 8;
  localparam int unsigned FIFO_DEPTH = 8;
  localparam logic [7:0]  BLANK_BYTE = 8'hff;
  localparam int unsigned POLL_BIT   = 7;

  // Select levels: {select_a, select_b, select_c, select_d}
  localparam logic [3:0] SEL_WRITE  = 4'h7;
  localparam logic [3:0] SEL_READ   = 4'h3;
  localparam logic [3:0] SEL_LOCK1  = 4'hf;
  localparam logic [3:0] SEL_LOCK2  = 4'hc;
  localparam logic [3:0] SEL_ERASE  = 4'h8;
  localparam logic [3:0] SEL_SIG    = 4'h0;

  typedef enum logic [2:0] {
    PFP_CMD_WRITE, PFP_CMD_READ, PFP_CMD_LOCK1, PFP_CMD_LOCK2,
    PFP_CMD_ERASE, PFP_CMD_SIG, PFP_CMD_NEXT, PFP_CMD_RESTART
  } pfp_cmd_e;

  typedef struct packed {
    pfp_cmd_e         cmd;
    logic [DATA_W-1:0] data;
  } pfp_req_s;

  // Pins driven toward the device
  typedef struct packed {
    logic       reset_hi;    // reset pin at logic high
    logic       vpp_en;      // raise reset pin to programming voltage
    logic       write_strobe;
    logic       address_increment_pin;
    logic [3:0] sel;
  } pfp_pins_s;
endpackage

/* File: design/pfp_fifo.sv */
/*
  Small flop-based FIFO with valid/ready on both sides.
  Assumes one clock and a synchronous active-low reset.
*/
`timescale 1ns/1ps
module pfp_fifo
  import pfp_pkg::*;
#(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic             core_clk,
  input  wire logic             rstn,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic [AW:0]      count, next_count;
  logic             push, pop;

  always_comb begin
    in_ready    = (count != DEPTH[AW:0]);
    out_valid   = (count != '0);
    out_data    = mem[rd_ptr];
    push        = in_valid && in_ready;
    pop         = out_valid && out_ready;
    next_wr_ptr = push ? AW'((wr_ptr == AW'(DEPTH - 1)) ? 0 : wr_ptr + 1'b1) : wr_ptr;
    next_rd_ptr = pop ? AW'((rd_ptr == AW'(DEPTH - 1)) ? 0 : rd_ptr + 1'b1) : rd_ptr;
    next_count  = count;
    if (push && !pop) begin
      next_count = count + 1'b1;
    end else if (pop && !push) begin
      next_count = count - 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count  <= next_count;
    end
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end
endmodule

/* File: design/pfp_host.sv */
/*
  Programmer-side sequencer for a parallel flash programming port. Takes commands
  from a user port through a FIFO and drives reset/VPP, strobe, selects, the
  address increment pin and the data port; samples ready/busy and the data port.
  Assumes external level shifters turn vpp_en into the programming voltage.
*/
`timescale 1ns/1ps
module pfp_host
  import pfp_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              rstn,
  input  wire pfp_req_s          req,
  input  wire logic              req_valid,
  output logic                   req_ready,
  output logic      [DATA_W-1:0] rsp_data,
  output logic                   rsp_valid,
  output logic                   rsp_refused,
  output logic                   busy,
  output logic                   power_ok,
  input  wire logic              power_up,
  output pfp_pins_s              pins,
  output logic      [DATA_W-1:0] data_port_o,
  output logic                   data_port_oe,
  input  wire logic [DATA_W-1:0] data_port_i,
  input  wire logic              ready_busy_pin
);
  typedef enum logic [3:0] {
    ST_OFF, ST_PWR_RST, ST_IDLE, ST_SETUP, ST_STROBE, ST_WAIT_BUSY, ST_WAIT_DONE,
    ST_READ, ST_INC_HI, ST_INC_LO, ST_PWR_DOWN
  } pfp_state_e;

  // Three-flop input sampling: change counts when stages two and three agree
  logic [2:0]        rb_sync;
  logic [DATA_W-1:0] dp_s1, dp_s2, dp_s3;
  logic              rb_stable, rb_level, next_rb_level;

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      rb_sync <= 3'h7;
      dp_s1   <= '0;
      dp_s2   <= '0;
      dp_s3   <= '0;
    end else begin
      rb_sync <= {rb_sync[1:0], ready_busy_pin};
      dp_s1   <= data_port_i;
      dp_s2   <= dp_s1;
      dp_s3   <= dp_s2;
    end
  end

  always_comb begin
    rb_stable     = (rb_sync[1] == rb_sync[2]);
    next_rb_level = rb_stable ? rb_sync[2] : rb_level;
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      rb_level <= 1'b1;
    end else begin
      rb_level <= next_rb_level;
    end
  end

  // Command FIFO in front of the sequencer
  pfp_req_s fifo_out;
  logic     fifo_valid, fifo_pop, fifo_in_ready;

  pfp_fifo #(.WIDTH($bits(pfp_req_s)), .DEPTH(FIFO_DEPTH)) u_fifo (
    .core_clk  (core_clk),
    .rstn      (rstn),
    .in_data   (req),
    .in_valid  (req_valid && req_ready),
    .in_ready  (fifo_in_ready),
    .out_data  (fifo_out),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop)
  );

  function automatic logic [3:0] sel_of(input pfp_cmd_e c);
    case (c)
      PFP_CMD_WRITE: sel_of = SEL_WRITE;
      PFP_CMD_LOCK1: sel_of = SEL_LOCK1;
      PFP_CMD_LOCK2: sel_of = SEL_LOCK2;
      PFP_CMD_ERASE: sel_of = SEL_ERASE;
      PFP_CMD_SIG:   sel_of = SEL_SIG;
      default:       sel_of = SEL_READ;
    endcase
  endfunction

  function automatic logic is_write_strobe(input pfp_cmd_e c);
    is_write_strobe = (c == PFP_CMD_WRITE) || (c == PFP_CMD_LOCK1) || (c == PFP_CMD_LOCK2) ||
              (c == PFP_CMD_ERASE);
  endfunction

  pfp_state_e        state, next_state;
  pfp_req_s          cur, next_cur;
  logic [CNT_W-1:0]  cnt, next_cnt;
  pfp_pins_s         next_pins;
  logic [DATA_W-1:0] next_dp_o, next_rsp_data;
  logic              next_dp_oe, next_rsp_valid, next_rsp_refused, next_busy;
  logic              next_power_ok, next_req_ready;
  logic              lock1_seen, lock2_seen, next_lock1_seen, next_lock2_seen;

  always_comb begin
    next_state       = state;
    next_cur         = cur;
    next_cnt         = (cnt != '0) ? cnt - 1'b1 : cnt;
    next_pins        = pins;
    next_dp_o        = data_port_o;
    next_dp_oe       = data_port_oe;
    next_rsp_data    = rsp_data;
    next_rsp_valid   = 1'b0;
    next_rsp_refused = 1'b0;
    next_busy        = 1'b1;
    next_power_ok    = power_ok;
    next_lock1_seen  = lock1_seen;
    next_lock2_seen  = lock2_seen;
    fifo_pop         = 1'b0;
    case (state)
      ST_OFF: begin
        // power-up order: reset and increment held low first
        next_pins = '0;
        next_dp_oe = 1'b0;
        if (power_up) begin
          next_state = ST_PWR_RST;
          next_cnt   = CNT_W'(SETUP_CYC);
        end
      end
      ST_PWR_RST: begin
        if (cnt == '0) begin
          // then reset and strobe high; counter clears on this rise
          next_pins.reset_hi     = 1'b1;
          next_pins.write_strobe = 1'b1;
          next_pins.sel          = SEL_READ;
          next_power_ok          = 1'b1;
          next_state             = ST_IDLE;
        end
      end
      ST_IDLE: begin
        next_busy = 1'b0;
        if (!power_up) begin
          // power-off: increment low, then reset low
          next_pins.address_increment_pin = 1'b0;
          next_pins.vpp_en = 1'b0;
          next_dp_oe = 1'b0;
          next_cnt   = CNT_W'(SETUP_CYC);
          next_state = ST_PWR_DOWN;
        end else if (fifo_valid && cnt == '0) begin
          fifo_pop  = 1'b1;
          next_cur  = fifo_out;
          next_busy = 1'b1;
          if (fifo_out.cmd == PFP_CMD_NEXT) begin
            next_pins.address_increment_pin = 1'b1;
            next_cnt   = CNT_W'(INC_CYC);
            next_state = ST_INC_HI;
          end else if (fifo_out.cmd == PFP_CMD_RESTART) begin
            // low-to-high on reset clears the counter
            next_pins.reset_hi = 1'b0;
            next_pins.vpp_en   = 1'b0;
            next_cnt   = CNT_W'(SETUP_CYC);
            next_state = ST_PWR_RST;
          end else if (fifo_out.cmd == PFP_CMD_WRITE && lock1_seen) begin
            // writes refused once lock one is set
            next_rsp_refused = 1'b1;
            next_rsp_valid   = 1'b1;
          end else if (!is_write_strobe(fifo_out.cmd) && fifo_out.cmd != PFP_CMD_SIG &&
                       lock2_seen) begin
            // readback refused once lock two is set
            next_rsp_refused = 1'b1;
            next_rsp_valid   = 1'b1;
          end else begin
            // select levels for the chosen operation
            next_pins.sel = sel_of(fifo_out.cmd);
            next_dp_o     = fifo_out.data;
            next_dp_oe    = (fifo_out.cmd == PFP_CMD_WRITE);
            next_pins.vpp_en = is_write_strobe(fifo_out.cmd);
            next_cnt   = CNT_W'(SETUP_CYC);
            next_state = ST_SETUP;
          end
        end
      end
      ST_SETUP: begin
        if (cnt == '0) begin
          if (is_write_strobe(cur.cmd)) begin
            next_pins.write_strobe = 1'b0;
            // erase strobe held low for 10 ms
            next_cnt   = (cur.cmd == PFP_CMD_ERASE) ? CNT_W'(ERASE_CYC) : CNT_W'(PROGW_CYC);
            next_state = ST_STROBE;
          end else begin
            next_state = ST_READ;
          end
        end
      end
      ST_STROBE: begin
        if (cnt == '0) begin
          next_pins.write_strobe = 1'b1;
          next_cnt = CNT_W'(WC_CYC);
          if (cur.cmd == PFP_CMD_ERASE) begin
            // erase clears locks, array back to blank
            next_lock1_seen = 1'b0;
            next_lock2_seen = 1'b0;
            next_cnt        = CNT_W'(SETUP_CYC);
            next_state      = ST_WAIT_DONE;
          end else begin
            next_state = ST_WAIT_BUSY;
          end
        end
      end
      ST_WAIT_BUSY: begin
        // busy expected low after strobe returns high
        if (!rb_level || cnt == '0) begin
          next_state = ST_WAIT_DONE;
        end
      end
      ST_WAIT_DONE: begin
        // self-timed write, bounded by the 2 ms cycle
        if ((rb_level && cnt <= CNT_W'(WC_CYC - SETUP_CYC)) || cnt == '0) begin
          if (cur.cmd == PFP_CMD_LOCK1) begin
            next_lock1_seen = 1'b1;
          end
          if (cur.cmd == PFP_CMD_LOCK2) begin
            next_lock2_seen = 1'b1;
          end
          // drop back to logic high to verify
          next_pins.vpp_en = 1'b0;
          next_dp_oe = 1'b0;
          next_pins.sel = (cur.cmd == PFP_CMD_WRITE) ? SEL_READ : next_pins.sel;
          next_cnt   = CNT_W'(SETUP_CYC);
          next_state = (cur.cmd == PFP_CMD_WRITE) ? ST_READ : ST_IDLE;
          if (cur.cmd != PFP_CMD_WRITE) begin
            next_rsp_valid = 1'b1;
            next_rsp_data  = BLANK_BYTE;
          end
        end
      end
      ST_READ: begin
        if (cnt == '0 && dp_s2 == dp_s3) begin
          // device drives code or signature byte
          next_rsp_data  = dp_s3;
          next_rsp_valid = 1'b1;
          // inverted poll bit means still writing
          next_rsp_refused = (cur.cmd == PFP_CMD_WRITE) &&
                             (dp_s3[POLL_BIT] != cur.data[POLL_BIT]);
          next_pins.sel = SEL_READ;
          next_state = ST_IDLE;
        end
      end
      ST_INC_HI: begin
        if (cnt == '0) begin
          // falling edge completes one increment pulse
          next_pins.address_increment_pin = 1'b0;
          next_cnt   = CNT_W'(BHIH_CYC);
          next_state = ST_INC_LO;
        end
      end
      ST_INC_LO: begin
        if (cnt == '0) begin
          next_state = ST_IDLE;
        end
      end
      ST_PWR_DOWN: begin
        if (cnt == '0) begin
          next_pins.reset_hi = 1'b0;
          next_power_ok = 1'b0;
          next_state = ST_OFF;
        end
      end
      default: begin
        next_state = ST_OFF;
      end
    endcase
    // Ready drops after each accept, so a registered ready never overruns a full queue
    next_req_ready = fifo_in_ready && !(req_valid && req_ready);
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      state        <= ST_OFF;
      cur          <= '0;
      cnt          <= '0;
      pins         <= '0;
      data_port_o  <= '0;
      data_port_oe <= 1'b0;
      rsp_data     <= '0;
      rsp_valid    <= 1'b0;
      rsp_refused  <= 1'b0;
      busy         <= 1'b1;
      power_ok     <= 1'b0;
      lock1_seen   <= 1'b0;
      lock2_seen   <= 1'b0;
      req_ready    <= 1'b0;
    end else begin
      state        <= next_state;
      cur          <= next_cur;
      cnt          <= next_cnt;
      pins         <= next_pins;
      data_port_o  <= next_dp_o;
      data_port_oe <= next_dp_oe;
      rsp_data     <= next_rsp_data;
      rsp_valid    <= next_rsp_valid;
      rsp_refused  <= next_rsp_refused;
      busy         <= next_busy;
      power_ok     <= next_power_ok;
      lock1_seen   <= next_lock1_seen;
      lock2_seen   <= next_lock2_seen;
      req_ready    <= next_req_ready;
    end
  end

  erase_len_a: assert property (@(posedge core_clk) disable iff (!rstn)
    (state == ST_SETUP && next_state == ST_STROBE && cur.cmd == PFP_CMD_ERASE) |=>
    (cnt == CNT_W'(ERASE_CYC))) else $error("erase strobe length wrong");
  strobe_vpp_a: assert property (@(posedge core_clk) disable iff (!rstn)
    $fell(pins.write_strobe) |-> pins.vpp_en && pins.reset_hi)
    else $error("strobe without programming voltage");
  inc_low_off_a: assert property (@(posedge core_clk) disable iff (!rstn)
    $fell(pins.reset_hi) && state == ST_OFF |-> !pins.address_increment_pin)
    else $error("reset dropped with increment high");
  pwr_up_a: assert property (@(posedge core_clk) disable iff (!rstn)
    $rose(pins.reset_hi) |-> pins.write_strobe && !pins.vpp_en)
    else $error("reset raised without strobe high");
  inc_pulse_a: assert property (@(posedge core_clk) disable iff (!rstn)
    $rose(pins.address_increment_pin) |=> pins.address_increment_pin [*8])
    else $error("increment pulse too short");
  lock_write_a: assert property (@(posedge core_clk) disable iff (!rstn)
    lock1_seen && state == ST_IDLE |-> !(next_pins.sel == SEL_WRITE && next_state == ST_SETUP))
    else $error("write issued after lock one");
  read_no_vpp_a: assert property (@(posedge core_clk) disable iff (!rstn)
    state == ST_READ |-> !pins.vpp_en && pins.write_strobe)
    else $error("read with programming voltage");
  oe_write_a: assert property (@(posedge core_clk) disable iff (!rstn)
    data_port_oe |-> pins.sel == SEL_WRITE)
    else $error("data port driven outside write");
endmodule

/* File: bench/pfp_dev_model.sv */
/*
  Behavioural model of the flash device that sits behind the programming pins.
  Assumes the pins change only on core_clk edges, so the model samples them there.
*/
`timescale 1ns/1ps
module pfp_dev_model
  import pfp_pkg::*;
#(
  parameter int unsigned BUSY_CYC = 600,
  // Identity bytes, values arbitrary
  parameter logic [23:0] SIG      = 24'h19724d
) (
  input  wire logic              core_clk,
  input  wire pfp_pins_s         pins,
  input  wire logic [DATA_W-1:0] data_port_o,
  input  wire logic              data_port_oe,
  output logic      [DATA_W-1:0] data_port_i,
  output logic                   ready_busy_pin
);
  logic [7:0]  mem [2048];
  logic [10:0] addr;
  logic [7:0]  last;
  logic [7:0]  rd;
  logic [3:0]  op;
  logic        lock1;
  logic        lock2;
  logic        busy;
  logic        prev_rst;
  logic        prev_inc;
  logic        prev_stb;
  int unsigned tmr;
  int unsigned low_cnt;
  wire logic   rst_lvl = pins.reset_hi | pins.vpp_en;

  initial begin
    foreach (mem[i]) mem[i] = BLANK_BYTE;
    {lock1, lock2, busy, prev_rst, prev_inc, prev_stb} = '0;
    {addr, last, op} = '0;
    tmr = 0;
    low_cnt = 0;
  end

  always @(posedge core_clk) begin
    prev_rst <= rst_lvl;
    prev_inc <= pins.address_increment_pin;
    prev_stb <= pins.write_strobe;
    low_cnt  <= pins.write_strobe ? 0 : low_cnt + 1;
    if (rst_lvl && !prev_rst) addr <= '0;
    else if (pins.address_increment_pin && !prev_inc) addr <= addr + 11'h1;
    if (busy) begin
      tmr <= tmr + 1;
      if (tmr + 1 >= BUSY_CYC) begin
        busy <= 1'b0;
        if (op == SEL_WRITE) mem[addr] <= mem[addr] & last;
      end
    end else if (pins.vpp_en && pins.write_strobe && !prev_stb) begin
      op   <= pins.sel;
      tmr  <= 0;
      last <= data_port_i;
      busy <= (pins.sel == SEL_WRITE && !lock1) || pins.sel == SEL_LOCK1
              || pins.sel == SEL_LOCK2;
      if (pins.sel == SEL_LOCK1) lock1 <= 1'b1;
      if (pins.sel == SEL_LOCK2) lock2 <= 1'b1;
      if (pins.sel == SEL_ERASE && low_cnt >= ERASE_CYC) begin
        foreach (mem[i]) mem[i] <= BLANK_BYTE;
        {lock1, lock2} <= 2'b00;
      end
    end
  end

  always_comb begin
    rd = BLANK_BYTE;
    if (pins.reset_hi && !pins.vpp_en && pins.write_strobe) begin
      if (pins.sel == SEL_READ && !(lock1 && lock2))
        rd = busy ? {~last[7], last[6:0]} : mem[addr];
      else if (pins.sel == SEL_SIG && addr < 11'h3)
        rd = SIG[8 * addr[1:0] +: 8];
    end
  end

  // Released port floats up to the pull-ups
  assign data_port_i    = data_port_oe ? data_port_o : rd;
  assign ready_busy_pin = !busy;
endmodule

/* File: bench/tb_pfp_host.sv */
/*
  Self-checking bench for the flash programming controller against a device model.
  Assumes the controller's own assertions sit inside the design files.
*/
`timescale 1ns/1ps
module tb_pfp_host
  import pfp_pkg::*;
();
  localparam int unsigned LIMIT = 60000;
  // Identity bytes, values arbitrary
  localparam logic [23:0] SIG   = 24'h19724d;
  logic              core_clk;
  logic              rstn;
  logic              req_valid;
  logic              req_ready;
  logic              rsp_valid;
  logic              rsp_refused;
  logic              busy;
  logic              power_ok;
  logic              power_up;
  logic              data_port_oe;
  logic              ready_busy_pin;
  logic              saw_full;
  logic [DATA_W-1:0] rsp_data;
  logic [DATA_W-1:0] data_port_o;
  logic [DATA_W-1:0] data_port_i;
  pfp_req_s          req;
  pfp_pins_s         pins;
  logic [8:0]        rq [$];
  int                mismatches;
  int                tests_run;
  int                cycles;

  pfp_host dut (
    .core_clk(core_clk), .rstn(rstn), .req(req), .req_valid(req_valid),
    .req_ready(req_ready), .rsp_data(rsp_data), .rsp_valid(rsp_valid),
    .rsp_refused(rsp_refused), .busy(busy), .power_ok(power_ok), .power_up(power_up),
    .pins(pins), .data_port_o(data_port_o), .data_port_oe(data_port_oe),
    .data_port_i(data_port_i), .ready_busy_pin(ready_busy_pin)
  );

  pfp_dev_model #(.SIG(SIG)) dev (
    .core_clk(core_clk), .pins(pins), .data_port_o(data_port_o),
    .data_port_oe(data_port_oe), .data_port_i(data_port_i),
    .ready_busy_pin(ready_busy_pin)
  );

  task automatic end_of_test();
    $display("checks %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Holds the request until the edge that accepts it
  task automatic push(input pfp_cmd_e c, input logic [7:0] d);
    req.cmd   <= c;
    req.data  <= d;
    req_valid <= 1'b1;
    do begin
      @(posedge core_clk);
      if (req_ready === 1'b0) saw_full = 1'b1;
    end while (req_ready !== 1'b1);
    req_valid <= 1'b0;
    @(posedge core_clk);
  endtask

  // A refused answer carries no defined byte, so only the flag is compared
  task automatic get(input string what, input logic [7:0] d, input logic r);
    logic [8:0] q;
    while (rq.size() == 0) @(posedge core_clk);
    q = rq.pop_front();
    if (r) check(what, {8'h00, q[8]}, 9'h001);
    else check(what, q, {1'b0, d});
  endtask

  // Answers pulse for one cycle, so they are queued as they appear
  always @(posedge core_clk) begin
    if (rsp_valid === 1'b1) rq.push_back({rsp_refused, rsp_data});
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      mismatches++;
      end_of_test();
    end
  end

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  initial begin
    {rstn, req_valid, power_up, saw_full} = '0;
    req = '0;
    mismatches = 0;
    tests_run = 0;
    cycles = 0;
    repeat (5) @(posedge core_clk);
    rstn <= 1'b1;
    @(posedge core_clk);
    check("pins after reset", pins, 9'h000);
    power_up <= 1'b1;
    while (power_ok !== 1'b1) @(posedge core_clk);
    check("powered pins", pins[7:4], 9'h00a);
    push(PFP_CMD_RESTART, 8'h00);
    for (int i = 0; i < 3; i++) begin
      push(PFP_CMD_SIG, 8'h00);
      get("signature", SIG[8 * i +: 8], 1'b0);
      push(PFP_CMD_NEXT, 8'h00);
    end
    $display("test signature done");
    push(PFP_CMD_RESTART, 8'h00);
    push(PFP_CMD_READ, 8'h00);
    get("blank byte", BLANK_BYTE, 1'b0);
    push(PFP_CMD_WRITE, 8'ha5);
    get("write verify", 8'ha5, 1'b0);
    push(PFP_CMD_NEXT, 8'h00);
    push(PFP_CMD_WRITE, 8'h3c);
    get("second write", 8'h3c, 1'b0);
    push(PFP_CMD_RESTART, 8'h00);
    push(PFP_CMD_WRITE, 8'hf0);
    get("rewrite without erase", 8'ha0, 1'b0);
    push(PFP_CMD_NEXT, 8'h00);
    push(PFP_CMD_READ, 8'h00);
    get("read back", 8'h3c, 1'b0);
    $display("test write done");
    push(PFP_CMD_RESTART, 8'h00);
    repeat (10) push(PFP_CMD_SIG, 8'h00);
    repeat (10) get("queued signature", SIG[7:0], 1'b0);
    check("queue filled", {8'h00, saw_full}, 9'h001);
    $display("test queue done");
    push(PFP_CMD_LOCK1, 8'h00);
    get("lock one", BLANK_BYTE, 1'b0);
    push(PFP_CMD_WRITE, 8'h11);
    get("write under lock", 8'h00, 1'b1);
    push(PFP_CMD_READ, 8'h00);
    get("read under lock one", 8'ha0, 1'b0);
    push(PFP_CMD_LOCK2, 8'h00);
    repeat (3) @(posedge core_clk);
    check("busy while locking", {8'h00, busy}, 9'h001);
    get("lock two", BLANK_BYTE, 1'b0);
    push(PFP_CMD_READ, 8'h00);
    get("read under both locks", 8'h00, 1'b1);
    push(PFP_CMD_SIG, 8'h00);
    get("signature under locks", SIG[7:0], 1'b0);
    repeat (2) @(posedge core_clk);
    check("idle not busy", {8'h00, busy}, 9'h000);
    $display("test locks done");
    power_up <= 1'b0;
    while (pins.reset_hi !== 1'b0 || pins.vpp_en !== 1'b0) @(posedge core_clk);
    check("increment at power off", {8'h00, pins.address_increment_pin}, 9'h000);
    check("port released", {8'h00, data_port_oe}, 9'h000);
    $display("test power off done");
    end_of_test();
  end
endmodule
